// ==== design/wdt_device.sv ====
// Watchdog and interval timer with keyed register access
`default_nettype none
module wdt_device #(
    parameter int unsigned OVF_OUT_LEN  = wdt_pkg::OVF_OUT_CYCLES,
    parameter int unsigned CHIP_RST_LEN = wdt_pkg::CHIP_RST_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    wdt_bus_if.dev    bus,
    input  wire logic ext_reset_n_i,
    input  wire logic standby_i,
    output logic      overflow_out_n_o,
    output logic      interval_irq_o,
    output logic      chip_reset_o,
    output logic      chip_reset_manual_o
);
    if (OVF_OUT_LEN < 1 || OVF_OUT_LEN > 1023) begin : g_bad_ovf_len
        $error("OVF_OUT_LEN must be 1 to 1023");
    end
    if (CHIP_RST_LEN < 1 || CHIP_RST_LEN > 1023) begin : g_bad_rst_len
        $error("CHIP_RST_LEN must be 1 to 1023");
    end

    typedef struct packed {
        logic [2:0]  ext_sync;
        logic        ext_level;
        logic [2:0]  stby_sync;
        logic        stby_level;
        logic [12:0] prescale;
        logic [7:0]  count_value;
        logic        interval_overflow_flag;
        logic        timer_mode_select;
        logic        timer_run;
        logic [2:0]  clock_divider_select;
        logic        watchdog_overflow_flag;
        logic        chip_reset_enable;
        logic        chip_reset_type;
        logic        ovf_read_one;
        logic        watchdog_overflow_flag_read_one;
        logic [9:0]  ovf_pulse_cnt;
        logic [9:0]  rst_pulse_cnt;
        logic        overflow_out_n;
        logic        chip_reset;
        logic        chip_reset_manual;
        logic [7:0]  rdata;
    } wdt_dev_state_s;

    localparam wdt_dev_state_s RESET_S = '{
        ext_sync:       3'h7,
        ext_level:      1'b1,
        overflow_out_n: 1'b1,
        default:        '0
    };

    // Prescaler tap mask for each divider code
    function automatic logic [12:0] div_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    div_mask = 13'h0001;
            3'h1:    div_mask = 13'h003f;
            3'h2:    div_mask = 13'h007f;
            3'h3:    div_mask = 13'h00ff;
            3'h4:    div_mask = 13'h01ff;
            3'h5:    div_mask = 13'h03ff;
            3'h6:    div_mask = 13'h0fff;
            default: div_mask = 13'h1fff;
        endcase
    endfunction : div_mask

    wdt_dev_state_s q;
    wdt_dev_state_s d;
    logic           wr_word;
    logic           rd_byte;
    logic [7:0]     key;
    logic [7:0]     lo;
    logic           csr_wr;
    logic           cnt_wr;
    logic           rst_clr;
    logic           rst_set;
    logic           tick;
    logic           wrap;
    logic           stby;
    logic [7:0]     csr_view;
    logic [7:0]     rst_view;

    always_comb begin
        d = q;
        d.ext_sync = {q.ext_sync[1:0], ext_reset_n_i};
        if (q.ext_sync[2] == q.ext_sync[1]) begin
            d.ext_level = q.ext_sync[2];
        end
        d.stby_sync = {q.stby_sync[1:0], standby_i};
        if (q.stby_sync[2] == q.stby_sync[1]) begin
            d.stby_level = q.stby_sync[2];
        end
        stby = q.stby_level;
        d.prescale = q.prescale + 13'h0001;
        d.rdata = 8'h00;

        key = bus.wdata[15:8];
        lo = bus.wdata[7:0];
        wr_word = bus.wr && (bus.size == wdt_pkg::SZ_WORD);
        rd_byte = bus.rd && (bus.size == wdt_pkg::SZ_BYTE);
        csr_wr = wr_word && (bus.addr == wdt_pkg::ADDR_CSR_WR)
                 && (key == wdt_pkg::KEY_CSR);
        cnt_wr = wr_word && (bus.addr == wdt_pkg::ADDR_CSR_WR)
                 && (key == wdt_pkg::KEY_CNT);
        rst_clr = wr_word && (bus.addr == wdt_pkg::ADDR_RST_WR)
                  && (key == wdt_pkg::KEY_RST_CLR) && (lo == wdt_pkg::RST_CLR_DATA);
        rst_set = wr_word && (bus.addr == wdt_pkg::ADDR_RST_WR)
                  && (key == wdt_pkg::KEY_RST_SET);

        tick = q.timer_run
               && ((q.prescale & div_mask(q.clock_divider_select))
                   == div_mask(q.clock_divider_select));
        wrap = tick && !cnt_wr && !stby && (q.count_value == 8'hff);

        csr_view = {q.interval_overflow_flag, q.timer_mode_select, q.timer_run,
                    wdt_pkg::CSR_RSVD, q.clock_divider_select};
        rst_view = {q.watchdog_overflow_flag, q.chip_reset_enable, q.chip_reset_type,
                    wdt_pkg::RST_RSVD};

        if (q.ovf_pulse_cnt != 10'h000) begin
            d.ovf_pulse_cnt = q.ovf_pulse_cnt - 10'h001;
        end
        if (q.rst_pulse_cnt != 10'h000) begin
            d.rst_pulse_cnt = q.rst_pulse_cnt - 10'h001;
        end

        // Byte reads; reading a set flag arms its clear
        if (rd_byte) begin
            case (bus.addr)
                wdt_pkg::ADDR_CSR_RD: begin
                    d.rdata = csr_view;
                    if (q.interval_overflow_flag) begin
                        d.ovf_read_one = 1'b1;
                    end
                end
                wdt_pkg::ADDR_CNT_RD: begin
                    d.rdata = q.count_value;
                end
                wdt_pkg::ADDR_RST_RD: begin
                    d.rdata = rst_view;
                    if (q.watchdog_overflow_flag) begin
                        d.watchdog_overflow_flag_read_one = 1'b1;
                    end
                end
                default: begin
                    d.rdata = 8'h00;
                end
            endcase
        end

        // Control writes
        if (csr_wr) begin
            d.timer_mode_select = lo[wdt_pkg::BIT_WT];
            d.timer_run = lo[wdt_pkg::BIT_TME];
            d.clock_divider_select = lo[2:0];
            if (!lo[wdt_pkg::BIT_OVF] && q.ovf_read_one) begin
                d.interval_overflow_flag = 1'b0;
                d.ovf_read_one = 1'b0;
            end
        end
        if (rst_clr && q.watchdog_overflow_flag_read_one) begin
            d.watchdog_overflow_flag = 1'b0;
            d.watchdog_overflow_flag_read_one = 1'b0;
        end
        if (rst_set) begin
            d.chip_reset_enable = lo[wdt_pkg::BIT_CHIP_RESET_ENABLE];
            d.chip_reset_type = lo[wdt_pkg::BIT_CHIP_RESET_TYPE];
        end

        // Counter: write beats increment, stop holds zero
        if (cnt_wr) begin
            d.count_value = lo;
        end else if (!q.timer_run) begin
            d.count_value = wdt_pkg::CNT_RESET;
        end else if (tick) begin
            d.count_value = q.count_value + 8'h01;
        end

        // Overflow events; a set wins over a same-cycle clear
        if (wrap && q.timer_mode_select) begin
            d.watchdog_overflow_flag = 1'b1;
            d.ovf_pulse_cnt = 10'(OVF_OUT_LEN);
            if (q.chip_reset_enable) begin
                d.rst_pulse_cnt = 10'(CHIP_RST_LEN);
                d.chip_reset_manual = q.chip_reset_type;
            end
            d.interval_overflow_flag = 1'b0;
            d.ovf_read_one = 1'b0;
            d.timer_mode_select = 1'b0;
            d.timer_run = 1'b0;
            d.clock_divider_select = 3'h0;
        end else if (wrap) begin
            d.interval_overflow_flag = 1'b1;
        end

        // Standby entry
        if (stby) begin
            d.interval_overflow_flag = 1'b0;
            d.timer_mode_select = 1'b0;
            d.timer_run = 1'b0;
            d.ovf_read_one = 1'b0;
            d.count_value = q.count_value;
            d.watchdog_overflow_flag = 1'b0;
            d.chip_reset_enable = 1'b0;
            d.chip_reset_type = 1'b0;
            d.watchdog_overflow_flag_read_one = 1'b0;
        end

        // Reset pin takes priority over everything
        if (!q.ext_level) begin
            d = '{
                ext_sync:       d.ext_sync,
                ext_level:      d.ext_level,
                stby_sync:      d.stby_sync,
                stby_level:     d.stby_level,
                overflow_out_n: 1'b1,
                default:        '0
            };
        end

        d.overflow_out_n = (d.ovf_pulse_cnt == 10'h000);
        d.chip_reset = (d.rst_pulse_cnt != 10'h000);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= RESET_S;
        end else begin
            q <= d;
        end
    end

    assign bus.rdata = q.rdata;
    assign overflow_out_n_o = q.overflow_out_n;
    assign interval_irq_o = q.interval_overflow_flag;
    assign chip_reset_o = q.chip_reset;
    assign chip_reset_manual_o = q.chip_reset_manual;
endmodule : wdt_device
`default_nettype wire

// ==== common/wdt_pkg.sv ====
// Shared constants for the watchdog and interval timer and its bus master
`default_nettype none
package wdt_pkg;
    localparam int unsigned ADDR_W = 28;

    // Register addresses on the device's own bus
    localparam logic [27:0] ADDR_CSR_WR = 28'h5ffffb8;
    localparam logic [27:0] ADDR_CSR_RD = 28'h5ffffb8;
    localparam logic [27:0] ADDR_CNT_RD = 28'h5ffffb9;
    localparam logic [27:0] ADDR_RST_WR = 28'h5ffffba;
    localparam logic [27:0] ADDR_RST_RD = 28'h5ffffbb;

    // Transfer sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    // Write keys in the upper byte
    localparam logic [7:0] KEY_CNT     = 8'h5a;
    localparam logic [7:0] KEY_CSR     = 8'ha5;
    localparam logic [7:0] KEY_RST_CLR = 8'ha5;
    localparam logic [7:0] KEY_RST_SET = 8'h5a;
    localparam logic [7:0] RST_CLR_DATA = 8'h00;

    // Field positions
    localparam int unsigned BIT_OVF  = 7;
    localparam int unsigned BIT_WT   = 6;
    localparam int unsigned BIT_TME  = 5;
    localparam int unsigned BIT_WATCHDOG_OVERFLOW_FLAG = 7;
    localparam int unsigned BIT_CHIP_RESET_ENABLE = 6;
    localparam int unsigned BIT_CHIP_RESET_TYPE = 5;

    // Reset values and fixed bits
    localparam logic [7:0] CSR_RESET = 8'h18;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] RST_RESET = 8'h1f;
    localparam logic [1:0] CSR_RSVD  = 2'h3;
    localparam logic [4:0] RST_RSVD  = 5'h1f;

    // Pulse lengths in system clock cycles
    localparam int unsigned OVF_OUT_CYCLES  = 128;
    localparam int unsigned CHIP_RST_CYCLES = 512;

    // Host command port offsets
    localparam logic [3:0] HOST_CNT_WR = 4'h0;
    localparam logic [3:0] HOST_CSR_WR = 4'h1;
    localparam logic [3:0] HOST_RST_WR = 4'h2;
    localparam logic [3:0] HOST_CLEAR  = 4'h3;
    localparam logic [3:0] HOST_SNAP   = 4'h4;
    localparam logic [3:0] HOST_STATUS = 4'h5;
endpackage : wdt_pkg
`default_nettype wire

// ==== common/wdt_bus_if.sv ====
// Register bus between the bus master and the timer
`default_nettype none
interface wdt_bus_if;
    logic [27:0] addr;
    logic [15:0] wdata;
    logic [1:0]  size;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;

    modport dev  (input addr, input wdata, input size, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output size, output wr, output rd, input rdata);
endinterface : wdt_bus_if
`default_nettype wire

// ==== design/wdt_host.sv ====
// Bus master that turns software commands into keyed timer accesses
`default_nettype none
module wdt_host (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    wdt_bus_if.host          bus,
    input  wire logic [3:0]  cmd_addr_i,
    input  wire logic [7:0]  cmd_wdata_i,
    input  wire logic        cmd_wr_i,
    input  wire logic        cmd_rd_i,
    output logic      [31:0] cmd_rdata_o
);
    typedef enum logic [1:0] {
        HS_IDLE,
        HS_RD,
        HS_CAPT
    } wdt_host_st_e;

    typedef struct packed {
        wdt_host_st_e    st;
        logic            snap;
        logic [1:0]      idx;
        logic [2:0][7:0] shadow;
        logic [27:0]     addr;
        logic [15:0]     wdata;
        logic [1:0]      size;
        logic            wr;
        logic            rd;
        logic [31:0]     cmd_rdata;
    } wdt_host_state_s;

    localparam wdt_host_state_s RESET_S = '{st: HS_IDLE, default: '0};

    // Read address for shadow slot 0 control, 1 counter, 2 reset control
    function automatic logic [27:0] rd_addr(input logic [1:0] idx);
        case (idx)
            2'h0:    rd_addr = wdt_pkg::ADDR_CSR_RD;
            2'h1:    rd_addr = wdt_pkg::ADDR_CNT_RD;
            default: rd_addr = wdt_pkg::ADDR_RST_RD;
        endcase
    endfunction : rd_addr

    wdt_host_state_s q;
    wdt_host_state_s d;
    logic            busy;

    always_comb begin
        d = q;
        d.wr = 1'b0;
        d.rd = 1'b0;
        d.cmd_rdata = 32'h0000_0000;
        busy = (q.st != HS_IDLE);
        if (cmd_rd_i && (cmd_addr_i == wdt_pkg::HOST_STATUS)) begin
            d.cmd_rdata = {7'h00, busy, q.shadow};
        end
        case (q.st)
            HS_IDLE: begin
                if (cmd_wr_i) begin
                    d.size = wdt_pkg::SZ_WORD;
                    d.addr = wdt_pkg::ADDR_CSR_WR;
                    case (cmd_addr_i)
                        wdt_pkg::HOST_CNT_WR: begin
                            d.wr = 1'b1;
                            d.wdata = {wdt_pkg::KEY_CNT, cmd_wdata_i};
                        end
                        wdt_pkg::HOST_CSR_WR: begin
                            d.wr = 1'b1;
                            d.wdata = {wdt_pkg::KEY_CSR, 1'b1, cmd_wdata_i[6:5],
                                       wdt_pkg::CSR_RSVD, cmd_wdata_i[2:0]};
                        end
                        wdt_pkg::HOST_RST_WR: begin
                            d.wr = 1'b1;
                            d.addr = wdt_pkg::ADDR_RST_WR;
                            d.wdata = {wdt_pkg::KEY_RST_SET, 1'b1, cmd_wdata_i[6:5],
                                       wdt_pkg::RST_RSVD};
                        end
                        wdt_pkg::HOST_CLEAR: begin
                            d.snap = 1'b0;
                            d.idx = cmd_wdata_i[0] ? 2'h2 : 2'h0;
                            d.rd = 1'b1;
                            d.size = wdt_pkg::SZ_BYTE;
                            d.addr = rd_addr(cmd_wdata_i[0] ? 2'h2 : 2'h0);
                            d.st = HS_RD;
                        end
                        wdt_pkg::HOST_SNAP: begin
                            d.snap = 1'b1;
                            d.idx = 2'h0;
                            d.rd = 1'b1;
                            d.size = wdt_pkg::SZ_BYTE;
                            d.addr = rd_addr(2'h0);
                            d.st = HS_RD;
                        end
                        default: begin
                            d.wr = 1'b0;
                        end
                    endcase
                end
            end
            HS_RD: begin
                d.st = HS_CAPT;
            end
            HS_CAPT: begin
                d.shadow[q.idx] = bus.rdata;
                d.st = HS_IDLE;
                if (q.snap && (q.idx != 2'h2)) begin
                    d.idx = q.idx + 2'h1;
                    d.rd = 1'b1;
                    d.size = wdt_pkg::SZ_BYTE;
                    d.addr = rd_addr(q.idx + 2'h1);
                    d.st = HS_RD;
                end else if (!q.snap && bus.rdata[7]) begin
                    d.wr = 1'b1;
                    d.size = wdt_pkg::SZ_WORD;
                    if (q.idx == 2'h0) begin
                        d.addr = wdt_pkg::ADDR_CSR_WR;
                        d.wdata = {wdt_pkg::KEY_CSR, 1'b0, bus.rdata[6:5],
                                   wdt_pkg::CSR_RSVD, bus.rdata[2:0]};
                    end else begin
                        d.addr = wdt_pkg::ADDR_RST_WR;
                        d.wdata = {wdt_pkg::KEY_RST_CLR, wdt_pkg::RST_CLR_DATA};
                    end
                end
            end
            default: begin
                d.st = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= RESET_S;
        end else begin
            q <= d;
        end
    end

    assign bus.addr = q.addr;
    assign bus.wdata = q.wdata;
    assign bus.size = q.size;
    assign bus.wr = q.wr;
    assign bus.rd = q.rd;
    assign cmd_rdata_o = q.cmd_rdata;
endmodule : wdt_host
`default_nettype wire

// ==== tb/wdt_monitor.sv ====
// Concurrent checks on the register bus and the timer outputs
`default_nettype none
module wdt_monitor #(
    parameter int unsigned OVF_OUT_LEN  = 8,
    parameter int unsigned CHIP_RST_LEN = 8
) (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [27:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [1:0]  size,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic        overflow_out_n_o,
    input wire logic        interval_irq_o,
    input wire logic        chip_reset_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [10:0] low_q;
    logic [10:0] high_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Pulse length counters
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            low_q  <= 11'h000;
            high_q <= 11'h000;
        end else begin
            low_q  <= overflow_out_n_o ? 11'h000 : low_q + 11'h001;
            high_q <= chip_reset_o ? high_q + 11'h001 : 11'h000;
        end
    end

    rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data without a read");
    strobe_excl_a: assert property (!(wr && rd))
        else $error("read and write strobes together");
    write_size_a: assert property (wr |-> size == wdt_pkg::SZ_WORD)
        else $error("write not word wide");
    write_key_a: assert property (wr |-> wdata[15:8] inside {8'h5a, 8'ha5})
        else $error("write without a valid key");
    rst_clear_a: assert property (wr && addr == wdt_pkg::ADDR_RST_WR
        && wdata[15:8] == 8'ha5 |-> wdata[7:0] == 8'h00) else $error("bad flag clear word");
    ovf_len_a: assert property ($rose(overflow_out_n_o) |-> low_q == 11'(OVF_OUT_LEN))
        else $error("overflow pulse length wrong");
    chip_len_a: assert property ($fell(chip_reset_o) |-> high_q == 11'(CHIP_RST_LEN))
        else $error("chip reset length wrong");
    irq_mode_a: assert property ($rose(interval_irq_o) |-> overflow_out_n_o && !chip_reset_o)
        else $error("interval irq with watchdog outputs");
    chip_with_ovf_a: assert property ($rose(chip_reset_o) |-> !overflow_out_n_o)
        else $error("chip reset without overflow pin");
    irq_clear_a: assert property ($fell(interval_irq_o) |->
        $past(wr, 1) || $past(wr, 2) || $past(wr, 3)) else $error("irq dropped without a write");

    cover property ($fell(overflow_out_n_o));
    cover property ($rose(chip_reset_o));
    cover property ($rose(interval_irq_o));
    cover property (rd ##1 rdata != 8'h00);
endmodule : wdt_monitor
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the timer and its bus master
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned LEN = 8;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [3:0]  cmd_addr_i = 4'h0;
    logic [7:0]  cmd_wdata_i = 8'h00;
    logic        cmd_wr_i = 1'b0;
    logic        cmd_rd_i = 1'b0;
    logic        ext_reset_n_i = 1'b1;
    logic        standby_i = 1'b0;
    logic [31:0] cmd_rdata_o;
    logic        overflow_out_n_o;
    logic        interval_irq_o;
    logic        chip_reset_o;
    logic        chip_reset_manual_o;
    logic [31:0] st;
    int          n_errors = 0;
    int          n_tests = 0;
    wdt_bus_if bus ();
    wdt_bus_if bus2 ();

    always #2.5 clk_i = ~clk_i;

    wdt_host wdt_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus.host),
        .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .cmd_wr_i(cmd_wr_i),
        .cmd_rd_i(cmd_rd_i), .cmd_rdata_o(cmd_rdata_o));
    wdt_device #(.OVF_OUT_LEN(LEN), .CHIP_RST_LEN(LEN)) wdt_device_inst (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .bus(bus.dev), .ext_reset_n_i(ext_reset_n_i),
        .standby_i(standby_i), .overflow_out_n_o(overflow_out_n_o),
        .interval_irq_o(interval_irq_o), .chip_reset_o(chip_reset_o),
        .chip_reset_manual_o(chip_reset_manual_o));
    wdt_device #(.OVF_OUT_LEN(LEN), .CHIP_RST_LEN(LEN)) wdt_device_inst2 (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .bus(bus2.dev), .ext_reset_n_i(1'b1), .standby_i(1'b0),
        .overflow_out_n_o(), .interval_irq_o(), .chip_reset_o(), .chip_reset_manual_o());
    wdt_monitor #(.OVF_OUT_LEN(LEN), .CHIP_RST_LEN(LEN)) wdt_monitor_inst (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .addr(bus.addr), .wdata(bus.wdata), .size(bus.size),
        .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .overflow_out_n_o(overflow_out_n_o),
        .interval_irq_o(interval_irq_o), .chip_reset_o(chip_reset_o));

    task automatic final_report;
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic give_up(input string nm);
        n_errors++;
        $display("[FAIL] %s expected event seen timeout", nm);
        final_report();
    endtask : give_up

    task automatic cmd(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cmd_addr_i  <= a;
        cmd_wdata_i <= d;
        cmd_wr_i    <= 1'b1;
        @(posedge clk_i);
        cmd_wr_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : cmd

    task automatic status;
        cmd(wdt_pkg::HOST_SNAP, 8'h00);
        @(posedge clk_i);
        cmd_addr_i <= wdt_pkg::HOST_STATUS;
        cmd_rd_i   <= 1'b1;
        @(posedge clk_i);
        cmd_rd_i <= 1'b0;
        #1;
        st = cmd_rdata_o;
    endtask : status

    task automatic expect_regs(input logic [7:0] ctl, input logic [7:0] cnt,
                               input logic [7:0] rsc);
        status();
        `CHK("control", ctl, st[7:0])
        `CHK("count", cnt, st[15:8])
        `CHK("reset control", rsc, st[23:16])
    endtask : expect_regs

    task automatic bwr(input logic [27:0] a, input logic [1:0] s, input logic [15:0] w);
        @(posedge clk_i);
        bus2.addr  <= a;
        bus2.size  <= s;
        bus2.wdata <= w;
        bus2.wr    <= 1'b1;
        @(posedge clk_i);
        bus2.wr    <= 1'b0;
        bus2.wdata <= ~w;
    endtask : bwr

    task automatic brd(input logic [27:0] a, input logic [1:0] s, input logic [7:0] exp);
        @(posedge clk_i);
        bus2.addr <= a;
        bus2.size <= s;
        bus2.rd   <= 1'b1;
        @(posedge clk_i);
        bus2.rd   <= 1'b0;
        bus2.addr <= ~a;
        #1;
        `CHK("direct read", exp, bus2.rdata)
    endtask : brd

    task automatic t_direct;
        bwr(wdt_pkg::ADDR_CSR_WR, wdt_pkg::SZ_BYTE, 16'ha53f);
        bwr(wdt_pkg::ADDR_CSR_WR, wdt_pkg::SZ_LONG, 16'ha53f);
        bwr(wdt_pkg::ADDR_CSR_WR, wdt_pkg::SZ_WORD, 16'h3c3f);
        bwr(wdt_pkg::ADDR_RST_WR, wdt_pkg::SZ_WORD, 16'ha560);
        brd(wdt_pkg::ADDR_CSR_RD, wdt_pkg::SZ_BYTE, 8'h18);
        brd(wdt_pkg::ADDR_RST_RD, wdt_pkg::SZ_BYTE, 8'h1f);
        bwr(wdt_pkg::ADDR_CSR_WR, wdt_pkg::SZ_WORD, 16'ha5c3);
        brd(wdt_pkg::ADDR_CSR_RD, wdt_pkg::SZ_BYTE, 8'h5b);
        bwr(wdt_pkg::ADDR_RST_WR, wdt_pkg::SZ_WORD, 16'h5a60);
        brd(wdt_pkg::ADDR_RST_RD, wdt_pkg::SZ_BYTE, 8'h7f);
        brd(wdt_pkg::ADDR_RST_WR, wdt_pkg::SZ_BYTE, 8'h00);
        brd(wdt_pkg::ADDR_CNT_RD, wdt_pkg::SZ_WORD, 8'h00);
    endtask : t_direct

    task automatic t_divider;
        int div[8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
        int t;
        for (int c = 0; c < 8; c++) begin
            cmd(wdt_pkg::HOST_CSR_WR, 8'h20 | 8'(c));
            cmd(wdt_pkg::HOST_CNT_WR, 8'hfd);
            for (t = 0; t < 3 * div[c] + 8 && interval_irq_o !== 1'b1; t++) @(posedge clk_i);
            if (t == 3 * div[c] + 8) give_up("interval irq");
            `CHK("ticks in window", 1'b1, t >= 2 * div[c] - 10 && t < 3 * div[c] + 8)
            `CHK("overflow pin idle", 1'b1, overflow_out_n_o)
            status();
            `CHK("interval flag", 8'hb8 | 8'(c), st[7:0])
            `CHK("watchdog flag", 8'h1f, st[23:16])
            cmd(wdt_pkg::HOST_CLEAR, 8'h00);
            `CHK("irq cleared", 1'b0, interval_irq_o)
            cmd(wdt_pkg::HOST_CSR_WR, 8'(c));
            expect_regs(8'h18 | 8'(c), 8'h00, 8'h1f);
        end
    endtask : t_divider

    task automatic t_watchdog;
        int i;
        logic e;
        for (int k = 0; k < 2; k++) begin
            e = (k == 1);
            cmd(wdt_pkg::HOST_RST_WR, {1'b0, e, e, 5'h00});
            cmd(wdt_pkg::HOST_CSR_WR, 8'h60);
            cmd(wdt_pkg::HOST_CNT_WR, 8'hf0);
            for (i = 0; i < 100 && overflow_out_n_o !== 1'b0; i++) @(posedge clk_i);
            if (i == 100) give_up("overflow pin");
            repeat (2) @(posedge clk_i);
            #1;
            `CHK("chip reset", e, chip_reset_o)
            `CHK("reset type", e, chip_reset_manual_o)
            `CHK("no interval irq", 1'b0, interval_irq_o)
            repeat (20) @(posedge clk_i);
            expect_regs(8'h18, 8'h00, {1'b1, e, e, 5'h1f});
            cmd(wdt_pkg::HOST_CLEAR, 8'h01);
            expect_regs(8'h18, 8'h00, {1'b0, e, e, 5'h1f});
        end
    endtask : t_watchdog

    task automatic t_standby;
        cmd(wdt_pkg::HOST_RST_WR, 8'h60);
        cmd(wdt_pkg::HOST_CSR_WR, 8'h27);
        cmd(wdt_pkg::HOST_CNT_WR, 8'h42);
        standby_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        expect_regs(8'h1f, 8'h42, 8'h1f);
        standby_i <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask : t_standby

    task automatic t_ext_reset;
        cmd(wdt_pkg::HOST_RST_WR, 8'h60);
        cmd(wdt_pkg::HOST_CSR_WR, 8'h63);
        ext_reset_n_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        ext_reset_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        expect_regs(8'h18, 8'h00, 8'h1f);
    endtask : t_ext_reset

    initial begin
        bus2.addr  = 28'h0000000;
        bus2.wdata = 16'h0000;
        bus2.size  = 2'h0;
        bus2.wr    = 1'b0;
        bus2.rd    = 1'b0;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        expect_regs(8'h18, 8'h00, 8'h1f);
        t_direct();
        t_divider();
        t_watchdog();
        t_standby();
        t_ext_reset();
        final_report();
    end
endmodule : testbench
`default_nettype wire
